// *** hw/card_sel_pkg.sv ***
// constants, enumerations and carrier structs for the card host select decode
// What this block does
// - PC Card modes decode eleven address inputs with register-space select into four targets
// - True IDE uses only three low address bits to pick one of eight task-file registers
// - memory mode holds both battery status outputs permanently high
// - I/O mode drives status-changed low on ready or write-protect change, when enabled
// - I/O mode keeps binary audio negated when audio is unsupported
// - True IDE pass-diagnostic pin is a two-way master/slave handshake line
// - True IDE active/slave-present pin is a two-way handshake line for activity and presence
// - PC Card modes use both lane enables as card select and byte/word indication
// - access with the high lane enable always reaches the odd byte
// - low lane enable reaches even or odd byte by address bit 0 and high enable
// - first chip select enables task file, second enables alternate status and control
// - True IDE samples cable select: grounded makes master, open makes slave
// - task-file accesses use the low byte lanes, data-port transfers use all sixteen
// - DMA acknowledge is ignored entirely while no DMA operation is active
package card_sel_pkg;

    // operating mode of the card
    typedef enum logic [1:0] {MODE_MEMORY, MODE_IO, MODE_IDE} mode_e;

    // what the current access reaches
    typedef enum logic [2:0] {TGT_NONE, TGT_IO_PORT, TGT_MEM_PORT, TGT_CIS, TGT_CONFIG,
                              TGT_TASKFILE, TGT_CTRL_BLOCK, TGT_DATA_PORT} target_e;

    // byte-lane steering of the data bus
    typedef enum logic [2:0] {LANE_NONE, LANE_EVEN_LOW, LANE_ODD_LOW, LANE_ODD_HIGH, LANE_WORD} lane_e;

    localparam int ADDR_W = 11;
    localparam int TF_W = 3;
    // attribute space below this offset holds the information structure
    localparam logic [10:0] CONFIG_BASE = 11'h200;
    // task-file index of the 16-bit data port
    localparam logic [2:0] TF_DATA_INDEX = 3'h0;
    // reset values
    localparam logic [10:0] OFFSET_RST = 11'h000;
    localparam logic PIN_IDLE_RST = 1'b1;
    localparam logic CARD_DETECT_LEVEL = 1'b0;
    localparam logic IS_MASTER_RST = 1'b0;

    // decoded access, as presented to the rest of the card
    typedef struct packed {
        target_e target;
        logic [10:0] offset;
        lane_e lane;
        logic lowLaneOe;
        logic highLaneOe;
        logic wordXfer;
    } decode_s;

    // open-drain handshake pin as seen at the port
    typedef struct packed {
        logic pinOut;
        logic pinOe;
        logic seen;
    } odpin_s;

    // complete state of the top module
    typedef struct packed {
        decode_s dec;
        logic battStatOne;
        logic battStatTwo;
        logic chgPending;
        logic readyLast;
        logic wpLast;
        logic csCaptured;
        logic isMaster;
        odpin_s diag;
        odpin_s active_slave_present_n;
        logic cdA;
        logic cdB;
        logic selectConflict;
    } state_s;

endpackage

// *** hw/lane_steer.sv ***
// byte-lane steering from the two lane enables and address bit 0
`timescale 1ns/1ps
`default_nettype none
module lane_steer
(
    // lane enables and address
    input wire logic lowEnable_n,
    input wire logic highEnable_n,
    input wire logic addrBit0,
    // result
    output card_sel_pkg::lane_e lane
);

    // one-hot decision over the four enable combinations
    always_comb
    begin
        unique case ({highEnable_n, lowEnable_n})
            2'b00: lane = card_sel_pkg::LANE_WORD;
            2'b01: lane = card_sel_pkg::LANE_ODD_HIGH;
            2'b10: lane = addrBit0 ? card_sel_pkg::LANE_ODD_LOW : card_sel_pkg::LANE_EVEN_LOW;
            2'b11: lane = card_sel_pkg::LANE_NONE;
        endcase
    end

endmodule // lane_steer
`default_nettype wire

// *** hw/handshake_pin.sv ***
// open-drain handshake pin: pulls low on request, reports the wire level
`timescale 1ns/1ps
`default_nettype none
module handshake_pin
#(
    parameter bit ENABLED = 1'b1
)
(
    // drive request and wire level
    input wire logic assertReq,
    input wire logic pinIn_n,
    // pin drive and observation
    output card_sel_pkg::odpin_s pin
);

    // only ever drive low; the pull-up makes the high level
    always_comb
    begin
        pin.pinOut = 1'b0;
        pin.pinOe = ENABLED & assertReq;
        pin.seen = ENABLED & ~pinIn_n;
    end

endmodule // handshake_pin
`default_nettype wire

// *** hw/card_host_select_decode.sv ***
// select, address and byte-lane decode of the card host port, with status pins
`timescale 1ns/1ps
`default_nettype none
module card_host_select_decode
#(
    parameter bit AUDIO_SUPPORTED = 1'b0
)
(
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // mode and address
    input wire card_sel_pkg::mode_e mode,
    input wire logic [card_sel_pkg::ADDR_W-1:0] address,
    input wire logic attrSpace_n,
    input wire logic ioCycle,
    // PC Card lane enables
    input wire logic low_lane_enable_n,
    input wire logic high_lane_enable_n,
    // True IDE selects and DMA
    input wire logic taskfile_select_n,
    input wire logic ctrl_block_select_n,
    input wire logic dma_ack_n,
    input wire logic dmaActive,
    // card state feeding the status pins
    input wire logic readyState,
    input wire logic writeProtect,
    input wire logic statusChgEnable,
    input wire logic statusChgClear,
    input wire logic audioIn_n,
    // master/slave handshake
    input wire logic cable_select_n,
    input wire logic diagPassed,
    input wire logic driveActive,
    input wire logic pass_diag_n_in,
    input wire logic active_slave_present_n_in,
    // decoded access
    output card_sel_pkg::decode_s access,
    output logic selectConflict,
    // battery status / status changed / audio pins
    output logic battery_stat_one,
    output logic battery_stat_two,
    // handshake pin drive
    output logic pass_diag_n_out,
    output logic pass_diag_n_oe,
    output logic active_slave_present_n_out,
    output logic active_slave_present_n_oe,
    // handshake results
    output logic isMaster,
    output logic peerDiagSeen,
    output logic peerPresentSeen,
    // card detect pins
    output logic card_detect_a_n,
    output logic card_detect_b_n
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    card_sel_pkg::state_s st_ff;
    card_sel_pkg::state_s nxt_st;
    card_sel_pkg::lane_e pcLane;
    card_sel_pkg::odpin_s diagPin;
    card_sel_pkg::odpin_s daspPin;
    logic inIde;
    logic slaveRole;
    logic dmaTaken;

    assign inIde = (mode == card_sel_pkg::MODE_IDE);
    assign slaveRole = st_ff.csCaptured & ~st_ff.isMaster;
    // a floating acknowledge must not disturb a non-DMA card
    assign dmaTaken = dmaActive & ~dma_ack_n;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // PC Card byte-lane steering
    lane_steer u_lane
    (
        .lowEnable_n(low_lane_enable_n),
        .highEnable_n(high_lane_enable_n),
        .addrBit0(address[0]),
        .lane(pcLane)
    );

    // slave reports passed diagnostics on the pass-diagnostic line
    handshake_pin #(.ENABLED(1'b1)) u_diag
    (
        .assertReq(inIde & slaveRole & diagPassed),
        .pinIn_n(pass_diag_n_in),
        .pin(diagPin)
    );

    // slave announces presence, either end flags activity
    handshake_pin #(.ENABLED(1'b1)) u_active_slave_present_n
    (
        .assertReq(inIde & (driveActive | (slaveRole & diagPassed))),
        .pinIn_n(active_slave_present_n_in),
        .pin(daspPin)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    // decode, status pins and handshake all settle here
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.dec.target = card_sel_pkg::TGT_NONE;
        nxt_st.dec.offset = card_sel_pkg::OFFSET_RST;
        nxt_st.dec.lane = card_sel_pkg::LANE_NONE;
        nxt_st.dec.lowLaneOe = 1'b0;
        nxt_st.dec.highLaneOe = 1'b0;
        nxt_st.dec.wordXfer = 1'b0;
        nxt_st.selectConflict = 1'b0;
        nxt_st.cdA = card_sel_pkg::CARD_DETECT_LEVEL;
        nxt_st.cdB = card_sel_pkg::CARD_DETECT_LEVEL;

        // change tracking runs in every mode so no edge is missed on a mode switch
        nxt_st.readyLast = readyState;
        nxt_st.wpLast = writeProtect;

        if (inIde)
        begin
            // chip selects are negated during DMA; a stray one is flagged, not obeyed
            if (dmaTaken)
            begin
                nxt_st.dec.target = card_sel_pkg::TGT_DATA_PORT;
                nxt_st.dec.lane = card_sel_pkg::LANE_WORD;
                nxt_st.selectConflict = ~taskfile_select_n | ~ctrl_block_select_n;
            end
            else if (~taskfile_select_n & ~ctrl_block_select_n)
            begin
                // both selects at once reach nothing
                nxt_st.selectConflict = 1'b1;
            end
            else if (~taskfile_select_n)
            begin
                // upper address lines are grounded by the host and not looked at
                nxt_st.dec.target = card_sel_pkg::TGT_TASKFILE;
                nxt_st.dec.offset = {8'h00, address[card_sel_pkg::TF_W-1:0]};
                if (address[card_sel_pkg::TF_W-1:0] == card_sel_pkg::TF_DATA_INDEX)
                begin
                    nxt_st.dec.target = card_sel_pkg::TGT_DATA_PORT;
                    nxt_st.dec.lane = card_sel_pkg::LANE_WORD;
                end
                else
                begin
                    nxt_st.dec.lane = card_sel_pkg::LANE_EVEN_LOW;
                end
            end
            else if (~ctrl_block_select_n)
            begin
                nxt_st.dec.target = card_sel_pkg::TGT_CTRL_BLOCK;
                nxt_st.dec.offset = {8'h00, address[card_sel_pkg::TF_W-1:0]};
                nxt_st.dec.lane = card_sel_pkg::LANE_EVEN_LOW;
            end
        end
        else if (pcLane != card_sel_pkg::LANE_NONE)
        begin
            nxt_st.dec.lane = pcLane;
            nxt_st.dec.offset = address;
            if (~attrSpace_n)
            begin
                if ((mode == card_sel_pkg::MODE_IO) && ioCycle)
                begin
                    nxt_st.dec.target = card_sel_pkg::TGT_IO_PORT;
                end
                else if (address < card_sel_pkg::CONFIG_BASE)
                begin
                    nxt_st.dec.target = card_sel_pkg::TGT_CIS;
                end
                else
                begin
                    nxt_st.dec.target = card_sel_pkg::TGT_CONFIG;
                end
            end
            else
            begin
                nxt_st.dec.target = card_sel_pkg::TGT_MEM_PORT;
            end
        end

        // lane output enables follow the steering; none means bus undriven
        unique case (nxt_st.dec.lane)
            card_sel_pkg::LANE_NONE:
            begin
                nxt_st.dec.lowLaneOe = 1'b0;
            end
            card_sel_pkg::LANE_EVEN_LOW, card_sel_pkg::LANE_ODD_LOW:
            begin
                nxt_st.dec.lowLaneOe = 1'b1;
            end
            card_sel_pkg::LANE_ODD_HIGH:
            begin
                nxt_st.dec.highLaneOe = 1'b1;
            end
            card_sel_pkg::LANE_WORD:
            begin
                nxt_st.dec.lowLaneOe = 1'b1;
                nxt_st.dec.highLaneOe = 1'b1;
                nxt_st.dec.wordXfer = 1'b1;
            end
        endcase

        // sticky change flag: a new change in the clearing cycle survives the clear
        if (statusChgClear)
        begin
            nxt_st.chgPending = 1'b0;
        end
        if ((readyState != st_ff.readyLast) || (writeProtect != st_ff.wpLast))
        begin
            nxt_st.chgPending = 1'b1;
        end

        // battery-status pins carry different meanings per mode
        unique case (mode)
            card_sel_pkg::MODE_MEMORY:
            begin
                nxt_st.battStatOne = 1'b1;
                nxt_st.battStatTwo = 1'b1;
            end
            card_sel_pkg::MODE_IO:
            begin
                nxt_st.battStatOne = ~(statusChgEnable & nxt_st.chgPending);
                nxt_st.battStatTwo = AUDIO_SUPPORTED ? audioIn_n : 1'b1;
            end
            card_sel_pkg::MODE_IDE:
            begin
                nxt_st.battStatOne = card_sel_pkg::PIN_IDLE_RST;
                nxt_st.battStatTwo = card_sel_pkg::PIN_IDLE_RST;
            end
            default:
            begin
                nxt_st.battStatOne = card_sel_pkg::PIN_IDLE_RST;
                nxt_st.battStatTwo = card_sel_pkg::PIN_IDLE_RST;
            end
        endcase

        // cable select is caught once, on the first enabled cycle in IDE mode
        if (inIde && !st_ff.csCaptured)
        begin
            nxt_st.csCaptured = 1'b1;
            nxt_st.isMaster = ~cable_select_n;
        end

        // handshake pins; the pin is driven only in IDE mode
        nxt_st.diag = diagPin;
        nxt_st.active_slave_present_n = daspPin;
        if (!inIde)
        begin
            nxt_st.diag.seen = 1'b0;
            nxt_st.active_slave_present_n.seen = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    // all state frozen while the clock enable is low
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= '0;
            st_ff.battStatOne <= card_sel_pkg::PIN_IDLE_RST;
            st_ff.battStatTwo <= card_sel_pkg::PIN_IDLE_RST;
            st_ff.readyLast <= 1'b0;
            st_ff.isMaster <= card_sel_pkg::IS_MASTER_RST;
            st_ff.cdA <= card_sel_pkg::CARD_DETECT_LEVEL;
            st_ff.cdB <= card_sel_pkg::CARD_DETECT_LEVEL;
        end
        else if (clkEn)
        begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, each straight from the state register

    assign access = st_ff.dec;
    assign selectConflict = st_ff.selectConflict;
    assign battery_stat_one = st_ff.battStatOne;
    assign battery_stat_two = st_ff.battStatTwo;
    assign pass_diag_n_out = st_ff.diag.pinOut;
    assign pass_diag_n_oe = st_ff.diag.pinOe;
    assign active_slave_present_n_out = st_ff.active_slave_present_n.pinOut;
    assign active_slave_present_n_oe = st_ff.active_slave_present_n.pinOe;
    assign isMaster = st_ff.isMaster;
    assign peerDiagSeen = st_ff.diag.seen;
    assign peerPresentSeen = st_ff.active_slave_present_n.seen;
    assign card_detect_a_n = st_ff.cdA;
    assign card_detect_b_n = st_ff.cdB;

endmodule // card_host_select_decode
`default_nettype wire

// *** tb/card_sel_asserts.sv ***
// port assertions of the card host select decode
`timescale 1ns/1ps
`default_nettype none
module card_sel_asserts
#(
    parameter bit AUDIO_SUPPORTED = 1'b0
)
(
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // access inputs
    input wire card_sel_pkg::mode_e mode,
    input wire logic [card_sel_pkg::ADDR_W-1:0] address,
    input wire logic low_lane_enable_n,
    input wire logic high_lane_enable_n,
    input wire logic taskfile_select_n,
    input wire logic ctrl_block_select_n,
    input wire logic dma_ack_n,
    input wire logic dmaActive,
    input wire logic readyState,
    input wire logic statusChgEnable,
    // watched outputs
    input wire card_sel_pkg::decode_s access,
    input wire logic selectConflict,
    input wire logic battery_stat_one,
    input wire logic battery_stat_two,
    input wire logic pass_diag_n_oe,
    input wire logic active_slave_present_n_oe,
    input wire logic card_detect_a_n,
    input wire logic card_detect_b_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // access classes; a taken dma wins over selects
    logic pcMode;
    logic ideOne;
    assign pcMode = clkEn && mode != card_sel_pkg::MODE_IDE;
    assign ideOne = clkEn && mode == card_sel_pkg::MODE_IDE && !(dmaActive && !dma_ack_n)
        && (taskfile_select_n != ctrl_block_select_n);
    // watched change, then the pin falls
    sequence chg_seen;
        clkEn && mode == card_sel_pkg::MODE_IO && statusChgEnable && $changed(readyState);
    endsequence
    sequence stat_low;
        ##[1:2] !battery_stat_one;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    mem_batt_high_a: assert property (clkEn && mode == card_sel_pkg::MODE_MEMORY |=> battery_stat_one && battery_stat_two)
        else $error("battery low in memory");
    audio_negated_a: assert property (!AUDIO_SUPPORTED && clkEn && mode == card_sel_pkg::MODE_IO |=> battery_stat_two)
        else $error("audio asserted");
    stat_chg_low_a: assert property (chg_seen |-> stat_low)
        else $error("change not signalled");
    detect_grounded_a: assert property (!card_detect_a_n && !card_detect_b_n)
        else $error("card detect not low");
    no_enable_idle_a: assert property (pcMode && low_lane_enable_n && high_lane_enable_n |=> access.target ==
        card_sel_pkg::TGT_NONE && !access.lowLaneOe && !access.highLaneOe)
        else $error("unselected access driven");
    high_odd_lane_a: assert property (pcMode && low_lane_enable_n && !high_lane_enable_n |=>
        access.lane == card_sel_pkg::LANE_ODD_HIGH && access.highLaneOe && !access.lowLaneOe)
        else $error("high lane wrong");
    low_lane_steer_a: assert property (pcMode && !low_lane_enable_n && high_lane_enable_n |=> access.lowLaneOe &&
        access.lane == ($past(address[0]) ? card_sel_pkg::LANE_ODD_LOW : card_sel_pkg::LANE_EVEN_LOW))
        else $error("low enable steering wrong");
    word_both_a: assert property (pcMode && !low_lane_enable_n && !high_lane_enable_n |=> access.wordXfer &&
        access.lane == card_sel_pkg::LANE_WORD && access.offset == $past(address))
        else $error("word access wrong");
    ide_taskfile_a: assert property (ideOne && !taskfile_select_n |=> access.offset == {8'h00, $past(address[2:0])}
        && access.target != card_sel_pkg::TGT_CTRL_BLOCK)
        else $error("task file decode wrong");
    ctrl_block_a: assert property (ideOne && !ctrl_block_select_n |=> access.target == card_sel_pkg::TGT_CTRL_BLOCK
        && access.lane == card_sel_pkg::LANE_EVEN_LOW)
        else $error("ctrl decode wrong");
    dma_word_a: assert property (clkEn && mode == card_sel_pkg::MODE_IDE && dmaActive && !dma_ack_n |=>
        access.target == card_sel_pkg::TGT_DATA_PORT && access.wordXfer)
        else $error("dma not a data word");
    select_clash_a: assert property (clkEn && mode == card_sel_pkg::MODE_IDE && !taskfile_select_n &&
        !ctrl_block_select_n |=> selectConflict)
        else $error("select clash not flagged");
    pins_quiet_a: assert property (pcMode |=> !pass_diag_n_oe && !active_slave_present_n_oe)
        else $error("pin driven outside ide");
endmodule // card_sel_asserts
`default_nettype wire

// *** tb/handshake_peer.sv ***
// peer drive on the two handshake wires
`timescale 1ns/1ps
`default_nettype none
module handshake_peer
(
    // pull requests
    input wire logic cardDiagOe,
    input wire logic cardDaspOe,
    input wire logic peerDiag,
    input wire logic peerDasp,
    // resolved wire levels
    output logic diagWire_n,
    output logic daspWire_n
);
    // open drain: low while anyone pulls
    assign diagWire_n = !(cardDiagOe || peerDiag);
    assign daspWire_n = !(cardDaspOe || peerDasp);
endmodule // handshake_peer
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench of the card select decode
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // inputs
    logic sys_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1;
    card_sel_pkg::mode_e mode = card_sel_pkg::MODE_MEMORY;
    logic [10:0] address = 11'h000;
    logic attrSpace_n = 1'b1, ioCycle = 1'b0, low_lane_enable_n = 1'b1, high_lane_enable_n = 1'b1;
    logic taskfile_select_n = 1'b1, ctrl_block_select_n = 1'b1, dma_ack_n = 1'b1, dmaActive = 1'b0;
    logic readyState = 1'b0, writeProtect = 1'b0, statusChgEnable = 1'b0, statusChgClear = 1'b0;
    logic audioIn_n = 1'b1, cable_select_n = 1'b0, diagPassed = 1'b0, driveActive = 1'b0;
    logic peerDiag = 1'b0, peerDasp = 1'b0, pass_diag_n_in, active_slave_present_n_in;
    // design outputs
    card_sel_pkg::decode_s access;
    logic selectConflict, battery_stat_one, battery_stat_two, pass_diag_n_out, pass_diag_n_oe;
    logic active_slave_present_n_out, active_slave_present_n_oe, isMaster, peerDiagSeen, peerPresentSeen;
    logic card_detect_a_n, card_detect_b_n;
    int mismatches = 0, checked = 0;
    always #25 sys_clk = ~sys_clk;
    card_host_select_decode DUT (.sys_clk, .rst_n, .clkEn, .mode, .address, .attrSpace_n, .ioCycle,
        .low_lane_enable_n, .high_lane_enable_n, .taskfile_select_n, .ctrl_block_select_n, .dma_ack_n,
        .dmaActive, .readyState, .writeProtect, .statusChgEnable, .statusChgClear, .audioIn_n, .cable_select_n,
        .diagPassed, .driveActive, .pass_diag_n_in, .active_slave_present_n_in, .access, .selectConflict,
        .battery_stat_one, .battery_stat_two, .pass_diag_n_out, .pass_diag_n_oe, .active_slave_present_n_out,
        .active_slave_present_n_oe, .isMaster, .peerDiagSeen, .peerPresentSeen, .card_detect_a_n, .card_detect_b_n);
    handshake_peer peer (.cardDiagOe(pass_diag_n_oe), .cardDaspOe(active_slave_present_n_oe), .peerDiag,
        .peerDasp, .diagWire_n(pass_diag_n_in), .daspWire_n(active_slave_present_n_in));
    ////////////////////////////////////////////////////////////////////////
    // drive at negedge, read after the next posedge
    task automatic step();
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic do_reset(input int n);
        rst_n = 1'b0;
        repeat (n) @(negedge sys_clk);
        rst_n = 1'b1;
    endtask
    // one pc card access
    task automatic pc_case(input logic io, at, input logic [10:0] a, input logic lo, hi);
        card_sel_pkg::target_e t;
        card_sel_pkg::lane_e l;
        mode = io ? card_sel_pkg::MODE_IO : card_sel_pkg::MODE_MEMORY;
        ioCycle = io;
        attrSpace_n = at;
        address = a;
        low_lane_enable_n = lo;
        high_lane_enable_n = hi;
        l = (!lo && !hi) ? card_sel_pkg::LANE_WORD : !hi ? card_sel_pkg::LANE_ODD_HIGH : !lo ?
            (a[0] ? card_sel_pkg::LANE_ODD_LOW : card_sel_pkg::LANE_EVEN_LOW) : card_sel_pkg::LANE_NONE;
        t = (lo && hi) ? card_sel_pkg::TGT_NONE : at ? card_sel_pkg::TGT_MEM_PORT : io ? card_sel_pkg::TGT_IO_PORT
            : (a < card_sel_pkg::CONFIG_BASE) ? card_sel_pkg::TGT_CIS : card_sel_pkg::TGT_CONFIG;
        step();
        cmp(access.target, t);
        cmp(access.lane, l);
        cmp(access.lowLaneOe, !lo);
        cmp(access.highLaneOe, lo && !hi || !lo && !hi);
        cmp(access.wordXfer, !lo && !hi);
        if (t != card_sel_pkg::TGT_NONE)
            cmp(access.offset, a);
    endtask
    // one ide access
    task automatic ide_case(input logic [10:0] a, input logic tf, ctrl, dack, dact);
        card_sel_pkg::target_e t;
        logic dma;
        logic both;
        mode = card_sel_pkg::MODE_IDE;
        address = a;
        taskfile_select_n = tf;
        ctrl_block_select_n = ctrl;
        dma_ack_n = dack;
        dmaActive = dact;
        dma = dact && !dack;
        both = !tf && !ctrl;
        t = dma ? card_sel_pkg::TGT_DATA_PORT : both ? card_sel_pkg::TGT_NONE : !ctrl ? card_sel_pkg::TGT_CTRL_BLOCK
            : (a[2:0] == card_sel_pkg::TF_DATA_INDEX) ? card_sel_pkg::TGT_DATA_PORT : card_sel_pkg::TGT_TASKFILE;
        step();
        cmp(access.target, t);
        cmp(selectConflict, both || (dma && !(tf && ctrl)));
        if (t != card_sel_pkg::TGT_NONE)
            cmp(access.wordXfer, t == card_sel_pkg::TGT_DATA_PORT);
        if (t != card_sel_pkg::TGT_NONE && !dma)
            cmp(access.offset, {8'h00, a[2:0]});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic test_pc_decode();
        pc_case(1'b0, 1'b0, 11'h010, 1'b0, 1'b1);
        pc_case(1'b0, 1'b0, 11'h1ff, 1'b0, 1'b1);
        pc_case(1'b0, 1'b0, 11'h200, 1'b0, 1'b0);
        pc_case(1'b0, 1'b1, 11'h7ff, 1'b1, 1'b0);
        pc_case(1'b1, 1'b0, 11'h3f6, 1'b0, 1'b1);
        pc_case(1'b1, 1'b1, 11'h401, 1'b0, 1'b1);
        pc_case(1'b0, 1'b0, 11'h123, 1'b1, 1'b1);
        $display("test_pc_decode done");
    endtask
    task automatic test_ide_decode();
        ide_case(11'h000, 1'b0, 1'b1, 1'b1, 1'b0);
        ide_case(11'h007, 1'b0, 1'b1, 1'b1, 1'b0);
        ide_case(11'h7fb, 1'b0, 1'b1, 1'b1, 1'b0);
        ide_case(11'h006, 1'b1, 1'b0, 1'b1, 1'b0);
        ide_case(11'h005, 1'b0, 1'b1, 1'b0, 1'b0);
        ide_case(11'h000, 1'b1, 1'b1, 1'b0, 1'b1);
        ide_case(11'h002, 1'b0, 1'b0, 1'b1, 1'b0);
        ide_case(11'h000, 1'b0, 1'b1, 1'b0, 1'b1);
        ide_case(11'h001, 1'b0, 1'b1, 1'b1, 1'b0);
        $display("test_ide_decode done");
    endtask
    // sticky flag: clear before each change
    task automatic test_status();
        mode = card_sel_pkg::MODE_MEMORY;
        step();
        cmp({battery_stat_one, battery_stat_two}, 16'h0003);
        cmp({card_detect_a_n, card_detect_b_n}, 16'h0000);
        mode = card_sel_pkg::MODE_IO;
        statusChgEnable = 1'b1;
        statusChgClear = 1'b1;
        step();
        statusChgClear = 1'b0;
        step();
        cmp(battery_stat_one, 1'b1);
        readyState = 1'b1;
        step();
        cmp(battery_stat_one, 1'b0);
        statusChgClear = 1'b1;
        step();
        statusChgClear = 1'b0;
        step();
        cmp(battery_stat_one, 1'b1);
        writeProtect = 1'b1;
        repeat (2) step();
        cmp(battery_stat_one, 1'b0);
        statusChgEnable = 1'b0;
        readyState = 1'b0;
        audioIn_n = 1'b0;
        repeat (2) step();
        cmp({battery_stat_one, battery_stat_two}, 16'h0003);
        $display("test_status done");
    endtask
    // role taken on first ide edge after reset
    task automatic test_handshake();
        mode = card_sel_pkg::MODE_IDE;
        cable_select_n = 1'b0;
        do_reset(2);
        step();
        cable_select_n = 1'b1;
        driveActive = 1'b1;
        repeat (2) step();
        cmp({isMaster, active_slave_present_n_oe, active_slave_present_n_out}, 16'h0006);
        driveActive = 1'b0;
        peerDiag = 1'b1;
        peerDasp = 1'b1;
        repeat (2) step();
        cmp({peerDiagSeen, peerPresentSeen, pass_diag_n_oe, active_slave_present_n_oe}, 16'h000c);
        peerDiag = 1'b0;
        peerDasp = 1'b0;
        diagPassed = 1'b1;
        do_reset(2);
        repeat (2) step();
        cmp({isMaster, pass_diag_n_oe, active_slave_present_n_oe, pass_diag_n_out}, 16'h0006);
        cmp(pass_diag_n_in, 1'b0);
        mode = card_sel_pkg::MODE_MEMORY;
        step();
        cmp({pass_diag_n_oe, peerDiagSeen}, 16'h0000);
        $display("test_handshake done");
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        do_reset(10);
        test_pc_decode();
        test_ide_decode();
        test_status();
        test_handshake();
        give_verdict();
    end
    // watchdog, tests need about fifty cycles
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        give_verdict();
    end
endmodule // testbench
bind card_host_select_decode card_sel_asserts #(.AUDIO_SUPPORTED(AUDIO_SUPPORTED)) checker_i (.sys_clk, .rst_n,
    .clkEn, .mode, .address, .low_lane_enable_n, .high_lane_enable_n, .taskfile_select_n, .ctrl_block_select_n,
    .dma_ack_n, .dmaActive, .readyState, .statusChgEnable, .access, .selectConflict, .battery_stat_one,
    .battery_stat_two, .pass_diag_n_oe, .active_slave_present_n_oe, .card_detect_a_n, .card_detect_b_n);
`default_nettype wire
